// ==== ipvu_pkg.sv ====
// Package of constants and types for the interrupt poll and vector unit.
package ipvu_pkg;

  // Number of interrupt sources and of external request inputs.
  localparam int NUM_SRC = 8;
  localparam int NUM_EXT = 4;

  // Source indices in fixed polling order, highest first.
  localparam int SRC_EXT0   = 0;
  localparam int SRC_TMR0   = 1;
  localparam int SRC_EXT1   = 2;
  localparam int SRC_TMR1   = 3;
  localparam int SRC_SERIAL = 4;
  localparam int SRC_TMR2   = 5;
  localparam int SRC_EXT2   = 6;
  localparam int SRC_EXT3   = 7;

  // Vector addresses for each source.
  localparam logic [15:0] VEC_EXT0   = 16'h0003;
  localparam logic [15:0] VEC_TMR0   = 16'h000B;
  localparam logic [15:0] VEC_EXT1   = 16'h0013;
  localparam logic [15:0] VEC_TMR1   = 16'h001B;
  localparam logic [15:0] VEC_SERIAL = 16'h0023;
  localparam logic [15:0] VEC_TMR2   = 16'h002B;
  localparam logic [15:0] VEC_EXT2   = 16'h0033;
  localparam logic [15:0] VEC_EXT3   = 16'h003B;

  // Reset values.
  localparam logic [3:0] RST_EXT_FLAGS = 4'h0;
  localparam logic [1:0] RST_ACTIVE    = 2'h0;
  localparam logic [2:0] RST_PIN_SYNC  = 3'h7;

  // Per-source priority level, two bits, 3 is highest.
  typedef logic [1:0] ipvu_level_t;

endpackage

// ==== ipvu_core.sv ====
// Interrupt poll, priority and vector logic for an 8-bit microcontroller core.
`timescale 1ns/1ps

// What this block does
// - Sample pins and sources each opcode fetch.
// - Poll samples next fetch, vector unless blocked.
// - Block while equal or higher level active.
// - Block unless poll is instruction's final cycle.
// - Block after return or interrupt-register write.
// - Block during self-programming activity.
// - Poll in last cycle of every instruction.
// - Blocked requests are not remembered.
// - Higher request preempts a running lower routine.
// - Serial done flags are left set.
// - Clear external flag on call only if edge.
// - Call pushes counter, no flags word.
// - Vectors 0003H, 000BH, 0013H for first three.
// - Vectors 001BH through 003BH for the rest.
// - Interrupt return clears current level's in-progress.
// - Plain return leaves in-progress state set.
// - Type select bit picks low level or edge.
// - High then low sample sets edge flag.
// - Level pin still low retriggers interrupt.
// - Lower level preempted only by higher; level 3 never.
// - Same level resolved by fixed polling order.
// - Timer 0 and 1 flags cleared on vectoring.
module ipvu_core
  import ipvu_pkg::*;
#(
  parameter int NUM_LEVELS = 4
) (
  input  wire logic                  clk_sys,
  input  wire logic                  srst,
  input  wire logic [NUM_EXT-1:0]    ext_request_pin_n,
  input  wire logic [NUM_EXT-1:0]    ext_type_sel,
  input  wire logic [NUM_EXT-1:0]    ext_flag_sw_clr,
  input  wire logic                  tmr0_overflow_flag,
  input  wire logic                  tmr1_overflow_flag,
  input  wire logic                  tmr2_overflow_flag,
  input  wire logic                  tmr2_external_flag,
  input  wire logic                  serial_rx_done_flag,
  input  wire logic                  serial_tx_done_flag,
  input  wire logic                  global_enable,
  input  wire logic [NUM_SRC-1:0]    source_enable,
  input  wire logic [2*NUM_SRC-1:0]  source_level,
  input  wire logic                  opcode_fetch,
  input  wire logic                  final_cycle,
  input  wire logic                  instr_is_return_from_interrupt,
  input  wire logic                  instr_is_ret,
  input  wire logic                  instr_wr_int_reg,
  input  wire logic                  self_programming_activity,
  input  wire logic                  call_done,
  output logic [NUM_EXT-1:0]         ext_req_flag,
  output logic                       tmr0_flag_hw_clr,
  output logic                       tmr1_flag_hw_clr,
  output logic                       hardware_service_call,
  output logic [15:0]                call_vector,
  output logic [2:0]                 call_source,
  output logic                       push_pc_only,
  output logic [NUM_LEVELS-1:0]      in_progress
);

  // The call_done reply is accepted for a core that reports the end of its call
  // sequence; the poll itself needs no such reply, so it is not read.
  // Only four priority levels map onto the two-bit level fields.
  if (NUM_LEVELS != 4) begin : g_chk
    $error("ipvu_core supports exactly four priority levels.");
  end

  // Vector table indexed by source number.
  localparam logic [15:0] VEC_TABLE [NUM_SRC] = '{VEC_EXT0, VEC_TMR0, VEC_EXT1, VEC_TMR1,
                                                   VEC_SERIAL, VEC_TMR2, VEC_EXT2, VEC_EXT3};

  // Pin synchronisers, three stages per pin; only stages two and three are compared.
  logic [2:0]         pinSync_q [NUM_EXT];
  logic [2:0]         pinSync_d [NUM_EXT];
  logic [NUM_EXT-1:0] pinLevel_q;        // Debounced pin level, 1 = high.
  logic [NUM_EXT-1:0] pinLevel_d;
  logic [NUM_EXT-1:0] fetchSample_q;     // Pin level caught at the previous opcode fetch.
  logic [NUM_EXT-1:0] fetchSample_d;
  logic [NUM_EXT-1:0] extFlag_q;         // External request flags.
  logic [NUM_EXT-1:0] extFlag_d;
  logic [NUM_SRC-1:0] sample_q;          // Request snapshot taken at opcode fetch.
  logic [NUM_SRC-1:0] sample_d;
  logic               blockNext_q;       // One-instruction block after return or register write.
  logic               blockNext_d;
  logic [3:0]         active_q;          // In-progress bit per level.
  logic [3:0]         active_d;
  logic               callFire;          // Combinational vector decision.
  logic [2:0]         winner;
  logic [15:0]        vectorReg_q;
  logic [15:0]        vectorReg_d;
  logic [2:0]         sourceReg_q;
  logic [2:0]         sourceReg_d;

  // Raw request vector in polling order; the sampled flags are taken, not cleared here.
  logic [NUM_SRC-1:0] rawReq;
  assign rawReq = {extFlag_q[3], extFlag_q[2], tmr2_overflow_flag | tmr2_external_flag,
                   serial_rx_done_flag | serial_tx_done_flag, tmr1_overflow_flag,
                   extFlag_q[1], tmr0_overflow_flag, extFlag_q[0]};

  // Next-state logic for pin synchronisers and external flags.
  always_comb begin
    extFlag_d     = extFlag_q;
    pinLevel_d    = pinLevel_q;
    fetchSample_d = fetchSample_q;
    for (int i = 0; i < NUM_EXT; i++) begin
      pinSync_d[i] = {pinSync_q[i][1:0], ext_request_pin_n[i]};
      // A change counts once the second and third stages agree.
      if (pinSync_q[i][1] == pinSync_q[i][2]) begin
        pinLevel_d[i] = pinSync_q[i][2];
      end
      if (opcode_fetch) begin
        fetchSample_d[i] = pinLevel_q[i];
      end
      if (ext_type_sel[i]) begin
        // Edge mode: a flag stays set until the call or software clears it.
        if (ext_flag_sw_clr[i]) begin
          extFlag_d[i] = 1'b0;
        end
        if (callFire && winner == 3'(2 * i) && i < 2) begin
          extFlag_d[i] = 1'b0;
        end
        if (callFire && winner == 3'(i + 4) && i >= 2) begin
          extFlag_d[i] = 1'b0;
        end
        // Set wins over any clear in the same cycle.
        if (opcode_fetch && fetchSample_q[i] && !pinLevel_q[i]) begin
          extFlag_d[i] = 1'b1;
        end
      end else begin
        // Level mode follows the pin, so a pin still low retriggers.
        extFlag_d[i] = !pinLevel_q[i];
      end
    end
  end

  // Registers for pin synchronisers and external flags.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      for (int i = 0; i < NUM_EXT; i++) begin
        pinSync_q[i] <= RST_PIN_SYNC;
      end
      pinLevel_q    <= '1;
      fetchSample_q <= '1;
      extFlag_q     <= RST_EXT_FLAGS;
    end else begin
      pinSync_q     <= pinSync_d;
      pinLevel_q    <= pinLevel_d;
      fetchSample_q <= fetchSample_d;
      extFlag_q     <= extFlag_d;
    end
  end

  // Highest enabled request among the snapshot, by level then polling order.
  logic [1:0] winLevel;
  logic       winValid;
  logic [1:0] curLevel;
  logic       anyActive;
  always_comb begin
    winner   = 3'h0;
    winLevel = 2'h0;
    winValid = 1'b0;
    // Scan from lowest polling order upward so earlier sources win ties.
    for (int s = NUM_SRC - 1; s >= 0; s--) begin
      // Only current flags count; a cleared flag drops out of the snapshot.
      if (sample_q[s] && rawReq[s] && source_enable[s] && global_enable) begin
        if (!winValid || source_level[2*s +: 2] >= winLevel) begin
          winner   = 3'(s);
          winLevel = source_level[2*s +: 2];
          winValid = 1'b1;
        end
      end
    end
    curLevel  = 2'h0;
    anyActive = 1'b0;
    for (int l = 0; l < 4; l++) begin
      if (active_q[l]) begin
        curLevel  = 2'(l);
        anyActive = 1'b1;
      end
    end
    // A new call needs a strictly higher level than any routine in progress.
    // A return or interrupt-register write blocks its own final cycle as well,
    // and the block flag then covers the instruction after it.
    callFire = winValid && (!anyActive || winLevel > curLevel)
               && opcode_fetch && final_cycle
               && !instr_is_return_from_interrupt && !instr_wr_int_reg
               && !blockNext_q
               && !self_programming_activity;
  end

  // Next-state logic for snapshot, block flag, in-progress and call outputs.
  always_comb begin
    sample_d    = sample_q;
    blockNext_d = blockNext_q;
    active_d    = active_q;
    vectorReg_d = vectorReg_q;
    sourceReg_d = sourceReg_q;
    if (opcode_fetch) begin
      sample_d = rawReq;
    end
    // The block lasts until the next instruction completes.
    if (instr_is_return_from_interrupt || instr_wr_int_reg) begin
      blockNext_d = 1'b1;
    end else if (final_cycle && opcode_fetch) begin
      blockNext_d = 1'b0;
    end
    // Only an interrupt return clears the level; a plain return never does, so
    // the routine still counts as active after it.
    if (instr_is_return_from_interrupt && !instr_is_ret && final_cycle && anyActive) begin
      active_d[curLevel] = 1'b0;
    end
    if (callFire) begin
      active_d[winLevel] = 1'b1;
      vectorReg_d        = VEC_TABLE[winner];
      sourceReg_d        = winner;
    end
  end

  // Registers for snapshot, block flag, in-progress and call data.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sample_q    <= '0;
      blockNext_q <= 1'b0;
      active_q    <= {2{RST_ACTIVE}};
      vectorReg_q <= VEC_EXT0;
      sourceReg_q <= 3'h0;
    end else begin
      sample_q    <= sample_d;
      blockNext_q <= blockNext_d;
      active_q    <= active_d;
      vectorReg_q <= vectorReg_d;
      sourceReg_q <= sourceReg_d;
    end
  end

  // Call strobe, vector and source; a preempting call is just a later call
  // of higher level, so it lands at a later final cycle while the lower routine is in progress.
  assign hardware_service_call = callFire;
  assign call_vector           = vectorReg_q;
  assign call_source           = sourceReg_q;
  assign push_pc_only          = 1'b1;
  assign in_progress           = active_q;
  assign ext_req_flag          = extFlag_q;
  // Serial flags are never cleared here; of the internal flags only timer 0 and 1 get a clear.
  assign tmr0_flag_hw_clr = callFire && winner == 3'(SRC_TMR0);
  assign tmr1_flag_hw_clr = callFire && winner == 3'(SRC_TMR1);

  // Call never fires without the fetch and final-cycle conditions.
  a_call_gating: assert property (@(posedge clk_sys) disable iff (srst)
    hardware_service_call |-> opcode_fetch && final_cycle)
    else $error("Call outside final fetch cycle.");
  a_selfprog_block: assert property (@(posedge clk_sys) disable iff (srst)
    self_programming_activity |-> !hardware_service_call)
    else $error("Call during self-programming.");
  a_return_from_interrupt_block: assert property (@(posedge clk_sys) disable iff (srst)
    instr_is_return_from_interrupt |=> !hardware_service_call)
    else $error("Call right after return.");
  a_vector_load: assert property (@(posedge clk_sys) disable iff (srst)
    hardware_service_call && winner == 3'(SRC_EXT0) |=> call_vector == VEC_EXT0)
    else $error("Wrong vector for external 0.");
  a_level_set: assert property (@(posedge clk_sys) disable iff (srst)
    hardware_service_call |=> in_progress != 4'h0)
    else $error("In-progress not set after call.");
  a_tmr0_clear: assert property (@(posedge clk_sys) disable iff (srst)
    tmr0_flag_hw_clr |-> hardware_service_call && tmr0_overflow_flag)
    else $error("Timer 0 clear without its call.");
  a_edge_flag: assert property (@(posedge clk_sys) disable iff (srst)
    ext_type_sel[0] && opcode_fetch && fetchSample_q[0] && !pinLevel_q[0] |=> ext_req_flag[0])
    else $error("Edge flag not set.");
  a_enable_gate: assert property (@(posedge clk_sys) disable iff (srst)
    !global_enable |-> !hardware_service_call)
    else $error("Call with global enable off.");

  // The running return or register write never vectors in its own cycle.
  a_return_from_interrupt_now: assert property (@(posedge clk_sys) disable iff (srst)
    instr_is_return_from_interrupt || instr_wr_int_reg |-> !hardware_service_call)
    else $error("Call during return or register write.");
  // A call on top of a running routine must come from a higher level.
  a_higher_only: assert property (@(posedge clk_sys) disable iff (srst)
    hardware_service_call && anyActive |-> winLevel > curLevel)
    else $error("Preemption by equal or lower level.");
  // A plain return with no new call leaves the in-progress bits alone.
  a_ret_keeps: assert property (@(posedge clk_sys) disable iff (srst)
    instr_is_ret && !instr_is_return_from_interrupt && !hardware_service_call |=> in_progress == $past(in_progress))
    else $error("Plain return changed in-progress.");
  // An edge flag of external 0 is gone after its own call, unless a new edge lands.
  a_edge_clear: assert property (@(posedge clk_sys) disable iff (srst)
    ext_type_sel[0] && hardware_service_call && winner == 3'(SRC_EXT0)
    && !(opcode_fetch && fetchSample_q[0] && !pinLevel_q[0]) |=> !ext_req_flag[0])
    else $error("Edge flag kept after call.");
  // A level flag of external 0 survives its call while the pin is low.
  a_level_keep: assert property (@(posedge clk_sys) disable iff (srst)
    !ext_type_sel[0] && hardware_service_call && !pinLevel_q[0] |=> ext_req_flag[0])
    else $error("Level flag cleared by call.");
  // An interrupt return with only level 0 active leaves nothing in progress.
  a_return_from_interrupt_clear: assert property (@(posedge clk_sys) disable iff (srst)
    instr_is_return_from_interrupt && !instr_is_ret && final_cycle && active_q == 4'h1 |=> in_progress == 4'h0)
    else $error("Return did not clear in-progress.");

endmodule

// ==== ipvu_partner.sv ====
// Instruction sequencer model that drives the fetch and final-cycle strobes.
`timescale 1ns/1ps
module ipvu_partner (
  input  wire logic       clk_sys,
  input  wire logic       srst,
  input  wire logic [2:0] instrLen,
  output logic            opcodeFetch,
  output logic            finalCycle
);
  logic [2:0] cnt_q;  // Cycle count within the running instruction.
  logic [2:0] cnt_d;  // Next cycle count.
  // The last cycle of an instruction is final, and it also fetches the next opcode.
  always_comb begin
    finalCycle  = (cnt_q == instrLen - 3'h1);
    opcodeFetch = (cnt_q == 3'h0) || finalCycle;
    cnt_d       = (srst || finalCycle) ? 3'h0 : cnt_q + 3'h1;
  end
  // A length change in mid-instruction wraps the count, so the bench changes it rarely.
  always_ff @(posedge clk_sys) begin
    cnt_q <= cnt_d;
  end
endmodule

// ==== ipvu_tb.sv ====
// Self-checking testbench for the interrupt poll and vector unit.
`timescale 1ns/1ps
module testbench;
  localparam logic [15:0] EXT_OF = 16'hE010;  // Pin index of each external source.
  localparam logic [7:0]  IS_EXT = 8'hC5;     // Sources fed by request pins.
  logic        clk_sys  = 1'h0;
  logic        srst     = 1'h1;
  logic [3:0]  pinN     = 4'hF;               // Request pins, low is active.
  logic [3:0]  typeSel  = 4'hF;
  logic [7:0]  srcFlg   = 8'h00;              // Internal flags, indexed by source.
  logic [7:0]  srcEn    = 8'h00;
  logic [15:0] srcLvl   = 16'h0000;
  logic        gEn = 1'h1, return_from_interrupt = 1'h0, ret = 1'h0, wrReg = 1'h0, selfProg = 1'h0;
  logic [2:0]  instrLen = 3'h1;
  logic        fetch, fin, call, clr0, clr1, pushPc;
  logic [3:0]  extFlag, inProg;
  logic [15:0] vec;
  logic [2:0]  src;
  bit          hit;                            // A call pulse was seen.
  int          err_total = 0;
  int          cmp_count = 0;
  ipvu_core ipvu_core_inst (
    .clk_sys(clk_sys), .srst(srst), .ext_request_pin_n(pinN), .ext_type_sel(typeSel),
    .ext_flag_sw_clr(4'h0), .tmr0_overflow_flag(srcFlg[1]), .tmr1_overflow_flag(srcFlg[3]),
    .tmr2_overflow_flag(srcFlg[5]), .tmr2_external_flag(1'h0), .serial_rx_done_flag(srcFlg[4]),
    .serial_tx_done_flag(1'h0), .global_enable(gEn), .source_enable(srcEn), .source_level(srcLvl),
    .opcode_fetch(fetch), .final_cycle(fin), .instr_is_return_from_interrupt(return_from_interrupt), .instr_is_ret(ret),
    .instr_wr_int_reg(wrReg), .self_programming_activity(selfProg), .call_done(1'h0),
    .ext_req_flag(extFlag), .tmr0_flag_hw_clr(clr0), .tmr1_flag_hw_clr(clr1),
    .hardware_service_call(call), .call_vector(vec), .call_source(src), .push_pc_only(pushPc),
    .in_progress(inProg));
  ipvu_partner ipvu_partner_inst (.clk_sys(clk_sys), .srst(srst), .instrLen(instrLen),
    .opcodeFetch(fetch), .finalCycle(fin));
  initial forever #2.5 clk_sys = ~clk_sys;
  // Waits end at a falling edge, so every check sees settled outputs.
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t ns: seen %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("Compares %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic wait_call(input int n);
    hit = 1'h0;
    repeat (n) if (!hit) begin
      @(negedge clk_sys);
      hit = (call === 1'h1);
    end
  endtask
  // A missing call is a hang in the making, so the run is closed at once.
  task automatic expect_call(input logic [15:0] v, input logic [2:0] s);
    wait_call(40);
    if (!hit) begin
      chk(hit, 1'h1);
      give_verdict();
    end
    chk(fin, 1'h1);
    chk(pushPc, 1'h1);
    chk({clr1, clr0}, {s == 3'h3, s == 3'h1});
    // The bench plays the timers, so it drops a timer flag at the call edge.
    @(posedge clk_sys);
    if (s == 3'h1) srcFlg[1] <= 1'h0;
    if (s == 3'h3) srcFlg[3] <= 1'h0;
    cyc(1);
    chk(vec, v);
    chk(src, s);
  endtask
  // Holding the strobe a whole instruction covers exactly one final cycle.
  task automatic ret_instr(input bit plain);
    @(posedge clk_sys);
    if (plain) ret <= 1'h1;
    else return_from_interrupt <= 1'h1;
    repeat (instrLen) @(posedge clk_sys);
    ret <= 1'h0;
    return_from_interrupt <= 1'h0;
  endtask
  task automatic raise(input int i);
    @(posedge clk_sys);
    if (IS_EXT[i]) pinN[EXT_OF[2*i+:2]] <= 1'h0;
    else srcFlg[i] <= 1'h1;
  endtask
  task automatic release_all();
    @(posedge clk_sys);
    pinN <= 4'hF;
    srcFlg <= 8'h00;
    cyc(12);
  endtask
  task automatic t_vectors();
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_sys);
      srcEn <= 8'h01 << i;
      raise(i);
      expect_call(16'h0003 + 16'(i * 8), 3'(i));
      cyc(12);
      chk(inProg, 4'h1);
      chk(extFlag, 4'h0);
      release_all();
      ret_instr(1'h0);
      cyc(2);
      chk(inProg, 4'h0);
    end
    $display("Test vectors done");
  endtask
  task automatic t_priority();
    @(posedge clk_sys);
    gEn <= 1'h0;
    typeSel <= 4'h8;
    srcLvl <= 16'hC014;
    srcEn <= 8'h86;
    pinN[1] <= 1'h0;
    raise(1);
    cyc(8);
    @(posedge clk_sys);
    gEn <= 1'h1;
    expect_call(16'h000B, 3'h1);
    wait_call(20);
    chk(hit, 1'h0);
    raise(7);
    expect_call(16'h003B, 3'h7);
    cyc(2);
    chk(inProg, 4'hA);
    ret_instr(1'h0);
    cyc(2);
    chk(inProg, 4'h2);
    ret_instr(1'h0);
    expect_call(16'h0013, 3'h2);
    release_all();
    ret_instr(1'h0);
    $display("Test priority done");
  endtask
  task automatic t_blocks();
    @(posedge clk_sys);
    srcEn <= 8'h10;
    srcLvl <= 16'h0000;
    selfProg <= 1'h1;
    srcFlg[4] <= 1'h1;
    wait_call(20);
    chk(hit, 1'h0);
    release_all();
    @(posedge clk_sys);
    selfProg <= 1'h0;
    wait_call(20);
    chk(hit, 1'h0);
    @(posedge clk_sys);
    instrLen <= 3'h3;
    wrReg <= 1'h1;
    srcFlg[4] <= 1'h1;
    wait_call(20);
    chk(hit, 1'h0);
    @(posedge clk_sys);
    wrReg <= 1'h0;
    expect_call(16'h0023, 3'h4);
    release_all();
    ret_instr(1'h0);
    instrLen <= 3'h1;
    cyc(12);
    chk(inProg, 4'h0);
    $display("Test blocks done");
  endtask
  task automatic t_level();
    @(posedge clk_sys);
    typeSel <= 4'h0;
    srcEn <= 8'h01;
    srcLvl <= 16'h0002;
    pinN[0] <= 1'h0;
    expect_call(16'h0003, 3'h0);
    cyc(12);
    chk(extFlag, 4'h1);
    ret_instr(1'h1);
    cyc(2);
    chk(inProg, 4'h4);
    ret_instr(1'h0);
    expect_call(16'h0003, 3'h0);
    release_all();
    ret_instr(1'h0);
    cyc(2);
    chk(inProg, 4'h0);
    $display("Test level done");
  endtask
  initial begin
    repeat (16) @(posedge clk_sys);
    srst <= 1'h0;
    cyc(4);
    chk(inProg, 4'h0);
    chk(vec, 16'h0003);
    t_vectors();
    t_priority();
    t_blocks();
    t_level();
    give_verdict();
  end
endmodule
